// file: rtpp_pkg.sv
// shared constants and carrier types for the double-buffer selector
// assumes a 16-bit word shared RAM with 13-bit word addresses
package rtpp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // descriptor block layout, word offsets from its base N
    // ------------------------------------------------------------
    localparam logic [12:0] DESC_CTL_OFS = 13'h0000;
    localparam logic [12:0] DESC_PTR_A_OFS = 13'h0001;
    localparam logic [12:0] DESC_PTR_B_OFS = 13'h0002;
    localparam logic [12:0] DESC_BCAST_OFS = 13'h0003;

    // ------------------------------------------------------------
    // data buffer layout, word offsets from the buffer start
    // ------------------------------------------------------------
    localparam logic [12:0] BUF_INFO_OFS = 13'h0000;
    localparam logic [12:0] BUF_TAG_OFS = 13'h0001;
    localparam logic [12:0] BUF_DATA_OFS = 13'h0002;

    // ------------------------------------------------------------
    // control word bit positions
    // ------------------------------------------------------------
    localparam int CW_DBL_SEL_BIT = 8;
    localparam int CW_SUSPEND_BIT = 9;
    localparam int CW_ACK_BIT = 10;
    localparam int CW_BUF_SEL_BIT = 11;
    localparam int CW_ACT_BUF_BIT = 12;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_EXT_CFG_IDX = 8'h4D;
    localparam logic [7:0] REG_BC_CFG_IDX = 8'h50;
    localparam logic [7:0] REG_STATUS_IDX = 8'h51;
    localparam int EXT_CFG_TSUP_BIT = 1;
    localparam int BC_CFG_SEP_BIT = 0;
    localparam logic [15:0] EXT_CFG_RST = 16'h0000;
    localparam logic [15:0] BC_CFG_RST = 16'h0000;

    // status register bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_CLEARING_BIT = 1;
    localparam int ST_LAST_B_BIT = 2;
    localparam int ST_LAST_BCAST_BIT = 3;
    localparam int ST_LAST_TOGGLE_BIT = 4;
    localparam int ST_LAST_ACK_BIT = 5;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [12:0] desc_addr;
        logic bcast;
    } rtpp_start_type;

    typedef struct packed {
        logic [15:0] info;
        logic [15:0] tag;
        logic complete;
        logic msg_error;
        logic illegal;
        logic busy;
        logic wc_legal;
    } rtpp_end_type;

    typedef struct packed {
        logic we;
        logic [12:0] addr;
        logic [15:0] wdata;
    } rtpp_ram_op_type;

endpackage

// file: rtpp_ram_port.sv
// single-word access unit toward the shared descriptor and buffer RAM
// assumes an external arbiter answers each request with a one-cycle ack
`timescale 1ns/1ns
module rtpp_ram_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input rtpp_pkg::rtpp_ram_op_type op_i,
    output logic op_done_o,
    output logic [15:0] op_rdata_o,
    output logic ram_req_o,
    output logic ram_we_o,
    output logic [12:0] ram_addr_o,
    output logic [15:0] ram_wdata_o,
    input wire logic ram_ack_i,
    input wire logic [15:0] ram_rdata_i
);
    import rtpp_pkg::*;

    logic busy_q, busy_d;
    rtpp_ram_op_type op_q, op_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;

    // ------------------------------------------------------------
    // request holding
    // ------------------------------------------------------------
    // request held until acked; a slow port stretches the access
    always_comb begin
        busy_d = busy_q;
        op_d = op_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        if (busy_q) begin
            if (ram_ack_i) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                rdata_d = ram_rdata_i;
            end
        end else if (op_valid_i) begin
            busy_d = 1'b1;
            op_d = op_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            op_q <= '0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            busy_q <= busy_d;
            op_q <= op_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    assign ram_req_o = busy_q;
    assign ram_we_o = busy_q & op_q.we;
    assign ram_addr_o = op_q.addr;
    assign ram_wdata_o = op_q.wdata;
    assign op_done_o = done_q;
    assign op_rdata_o = rdata_q;

endmodule

// file: rtpp_buffer_select.sv
// double-buffer (ping-pong) selector for remote terminal messages
// assumes the message engine and the RAM arbiter run on clk_i
`timescale 1ns/1ns

module rtpp_buffer_select #(
    parameter int RAM_WORDS = 8192
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // message engine
    input wire logic start_valid_i,
    input rtpp_pkg::rtpp_start_type start_i,
    output logic start_ready_o,
    output logic buf_valid_o,
    output logic [12:0] buf_addr_o,
    input wire logic word_valid_i,
    input wire logic word_we_i,
    input wire logic [15:0] word_wdata_i,
    output logic word_ready_o,
    output logic [15:0] word_rdata_o,
    input wire logic end_valid_i,
    input rtpp_pkg::rtpp_end_type end_i,
    output logic end_ready_o,
    output logic msg_done_o,
    // shared RAM
    output logic ram_req_o,
    output logic ram_we_o,
    output logic [12:0] ram_addr_o,
    output logic [15:0] ram_wdata_o,
    input wire logic ram_ack_i,
    input wire logic [15:0] ram_rdata_i
);
    import rtpp_pkg::*;

    typedef enum logic [10:0] {
        ST_CLEAR = 11'h001,
        ST_IDLE = 11'h002,
        ST_RD_CTL = 11'h004,
        ST_WR_CTL = 11'h008,
        ST_RD_PTR = 11'h010,
        ST_XFER = 11'h020,
        ST_WORD = 11'h040,
        ST_WR_INFO = 11'h080,
        ST_WR_TAG = 11'h100,
        ST_RD_CTL2 = 11'h200,
        ST_WR_CTL2 = 11'h400
    } rtpp_state_type;

    localparam logic [12:0] LAST_ADDR = 13'(RAM_WORDS - 1);

    // toggle qualification for a finished message
    function automatic logic may_toggle(input rtpp_end_type e, input logic tsup);
        if (tsup) begin
            may_toggle = e.complete & ~e.msg_error & ~e.illegal & ~e.busy & e.wc_legal;
        end else begin
            may_toggle = e.complete & ~e.msg_error;
        end
    endfunction

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    logic [15:0] ext_cfg_q, ext_cfg_d;
    logic [15:0] bc_cfg_q, bc_cfg_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [15:0] status_w;
    logic [7:0] reg_idx;
    logic reg_hit;
    logic tsup;
    logic bsep;

    assign reg_idx = wb_adr_i[9:2];
    assign reg_hit = (wb_adr_i[11:10] == 2'h0);
    assign tsup = ext_cfg_q[EXT_CFG_TSUP_BIT];
    assign bsep = bc_cfg_q[BC_CFG_SEP_BIT];

    // one wait state; unmapped addresses read zero and ignore writes
    always_comb begin
        ext_cfg_d = ext_cfg_q;
        bc_cfg_d = bc_cfg_q;
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d = 32'h0000_0000;
        if (ack_d && reg_hit) begin
            if (wb_we_i) begin
                if (reg_idx == REG_EXT_CFG_IDX) begin
                    if (wb_sel_i[0]) ext_cfg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) ext_cfg_d[15:8] = wb_dat_i[15:8];
                end
                if (reg_idx == REG_BC_CFG_IDX) begin
                    if (wb_sel_i[0]) bc_cfg_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) bc_cfg_d[15:8] = wb_dat_i[15:8];
                end
            end else begin
                case (reg_idx)
                    REG_EXT_CFG_IDX: dat_d = {16'h0000, ext_cfg_q};
                    REG_BC_CFG_IDX: dat_d = {16'h0000, bc_cfg_q};
                    REG_STATUS_IDX: dat_d = {16'h0000, status_w};
                    default: dat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_cfg_q <= EXT_CFG_RST;
            bc_cfg_q <= BC_CFG_RST;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ext_cfg_q <= ext_cfg_d;
            bc_cfg_q <= bc_cfg_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------
    // message sequencer
    // ------------------------------------------------------------
    rtpp_state_type state_q, state_d;
    logic pend_q, pend_d;
    logic [12:0] clr_q, clr_d;
    logic [12:0] desc_q, desc_d;
    logic bcast_q, bcast_d;
    logic [15:0] ctl_q, ctl_d;
    logic [12:0] ptr_ofs_q, ptr_ofs_d;
    logic [12:0] buf_q, buf_d;
    logic [7:0] cnt_q, cnt_d;
    rtpp_end_type end_q, end_d;
    logic alt_q, alt_d;
    logic use_b_q, use_b_d;
    logic last_tog_q, last_tog_d;
    logic bvalid_q, bvalid_d;
    logic done_q, done_d;
    logic op_valid;
    rtpp_ram_op_type op;
    logic op_done;
    logic [15:0] op_rdata;
    logic sep_bcast;

    // a separated broadcast goes to its own single buffer
    assign sep_bcast = bcast_q & bsep;

    always_comb begin
        state_d = state_q;
        pend_d = pend_q;
        clr_d = clr_q;
        desc_d = desc_q;
        bcast_d = bcast_q;
        ctl_d = ctl_q;
        ptr_ofs_d = ptr_ofs_q;
        buf_d = buf_q;
        cnt_d = cnt_q;
        end_d = end_q;
        alt_d = alt_q;
        use_b_d = use_b_q;
        last_tog_d = last_tog_q;
        bvalid_d = 1'b0;
        done_d = 1'b0;
        op_valid = 1'b0;
        op = '0;
        case (state_q)
            ST_CLEAR: begin
                op = '{we: 1'b1, addr: clr_q, wdata: 16'h0000};
                if (op_done) begin
                    clr_d = clr_q + 13'h0001;
                    if (clr_q == LAST_ADDR) state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start_valid_i) begin
                    desc_d = start_i.desc_addr;
                    bcast_d = start_i.bcast;
                    cnt_d = 8'h00;
                    state_d = ST_RD_CTL;
                end
            end
            ST_RD_CTL: begin
                op = '{we: 1'b0, addr: desc_q + DESC_CTL_OFS, wdata: 16'h0000};
                if (op_done) begin
                    ctl_d = op_rdata;
                    state_d = ST_WR_CTL;
                end
            end
            ST_WR_CTL: begin
                // acknowledge follows select and suspend at every fetch
                alt_d = ctl_q[CW_DBL_SEL_BIT] & ~ctl_q[CW_SUSPEND_BIT];
                use_b_d = ctl_q[CW_DBL_SEL_BIT] & ctl_q[CW_BUF_SEL_BIT];
                if (bcast_q && bsep) begin
                    ptr_ofs_d = DESC_BCAST_OFS;
                end else if (use_b_d) begin
                    ptr_ofs_d = DESC_PTR_B_OFS;
                end else begin
                    ptr_ofs_d = DESC_PTR_A_OFS;
                end
                op.we = 1'b1;
                op.addr = desc_q + DESC_CTL_OFS;
                op.wdata = ctl_q;
                op.wdata[CW_ACK_BIT] = alt_d;
                op.wdata[CW_ACT_BUF_BIT] = use_b_d;
                if (op_done) state_d = ST_RD_PTR;
            end
            ST_RD_PTR: begin
                // pointers are read only, so they stay fixed start addresses
                op = '{we: 1'b0, addr: desc_q + ptr_ofs_q, wdata: 16'h0000};
                if (op_done) begin
                    buf_d = op_rdata[12:0];
                    bvalid_d = 1'b1;
                    state_d = ST_XFER;
                end
            end
            ST_XFER: begin
                if (word_valid_i) begin
                    state_d = ST_WORD;
                end else if (end_valid_i) begin
                    end_d = end_i;
                    state_d = ST_WR_INFO;
                end
            end
            ST_WORD: begin
                // receive stores, transmit fetches; count restarts per message
                op.we = word_we_i;
                op.addr = buf_q + BUF_DATA_OFS + {5'h00, cnt_q};
                op.wdata = word_wdata_i;
                if (op_done) begin
                    cnt_d = cnt_q + 8'h01;
                    state_d = ST_XFER;
                end
            end
            ST_WR_INFO: begin
                op = '{we: 1'b1, addr: buf_q + BUF_INFO_OFS, wdata: end_q.info};
                if (op_done) state_d = ST_WR_TAG;
            end
            ST_WR_TAG: begin
                op = '{we: 1'b1, addr: buf_q + BUF_TAG_OFS, wdata: end_q.tag};
                if (op_done) state_d = ST_RD_CTL2;
            end
            ST_RD_CTL2: begin
                // re-read so host edits made during the message survive
                op = '{we: 1'b0, addr: desc_q + DESC_CTL_OFS, wdata: 16'h0000};
                if (op_done) begin
                    ctl_d = op_rdata;
                    state_d = ST_WR_CTL2;
                end
            end
            ST_WR_CTL2: begin
                op.we = 1'b1;
                op.addr = desc_q + DESC_CTL_OFS;
                op.wdata = ctl_q;
                // no toggle while acknowledge is low or for separated broadcasts
                if (alt_q && !sep_bcast && may_toggle(end_q, tsup)) begin
                    op.wdata[CW_BUF_SEL_BIT] = ~ctl_q[CW_BUF_SEL_BIT];
                end
                if (op_done) begin
                    last_tog_d = op.wdata[CW_BUF_SEL_BIT] ^ ctl_q[CW_BUF_SEL_BIT];
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // one access per state visit, one per address in ST_CLEAR; the pending flag stops a reissue
        if (state_q != ST_IDLE && state_q != ST_XFER) begin
            op_valid = ~pend_q;
            if (!pend_q) pend_d = 1'b1;
            if (op_done) pend_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_CLEAR;
            pend_q <= 1'b0;
            clr_q <= 13'h0000;
            desc_q <= 13'h0000;
            bcast_q <= 1'b0;
            ctl_q <= 16'h0000;
            ptr_ofs_q <= DESC_PTR_A_OFS;
            buf_q <= 13'h0000;
            cnt_q <= 8'h00;
            end_q <= '0;
            alt_q <= 1'b0;
            use_b_q <= 1'b0;
            last_tog_q <= 1'b0;
            bvalid_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            clr_q <= clr_d;
            desc_q <= desc_d;
            bcast_q <= bcast_d;
            ctl_q <= ctl_d;
            ptr_ofs_q <= ptr_ofs_d;
            buf_q <= buf_d;
            cnt_q <= cnt_d;
            end_q <= end_d;
            alt_q <= alt_d;
            use_b_q <= use_b_d;
            last_tog_q <= last_tog_d;
            bvalid_q <= bvalid_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // RAM access and outputs
    // ------------------------------------------------------------
    rtpp_ram_port u_ram_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .op_valid_i(op_valid),
        .op_i(op),
        .op_done_o(op_done),
        .op_rdata_o(op_rdata),
        .ram_req_o(ram_req_o),
        .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o),
        .ram_ack_i(ram_ack_i),
        .ram_rdata_i(ram_rdata_i)
    );

    assign start_ready_o = (state_q == ST_IDLE);
    assign end_ready_o = (state_q == ST_XFER) & ~word_valid_i;
    assign word_ready_o = (state_q == ST_WORD) & op_done;
    assign word_rdata_o = op_rdata;
    assign buf_valid_o = bvalid_q;
    assign buf_addr_o = buf_q;
    assign msg_done_o = done_q;

    always_comb begin
        status_w = 16'h0000;
        status_w[ST_BUSY_BIT] = (state_q != ST_IDLE);
        status_w[ST_CLEARING_BIT] = (state_q == ST_CLEAR);
        status_w[ST_LAST_B_BIT] = use_b_q;
        status_w[ST_LAST_BCAST_BIT] = sep_bcast;
        status_w[ST_LAST_TOGGLE_BIT] = last_tog_q;
        status_w[ST_LAST_ACK_BIT] = alt_q;
    end

endmodule

// file: rtpp_ram_model.sv
// shared ram seen from the host side: word store with a one-cycle ack
// assumes one request outstanding, held by the selector until acked
`timescale 1ns/1ns
module rtpp_ram_model (
    input wire logic clk_i,
    input wire logic [1:0] delay_i,
    input wire logic ram_req_i,
    input wire logic ram_we_i,
    input wire logic [12:0] ram_addr_i,
    input wire logic [15:0] ram_wdata_i,
    output logic ram_ack_o,
    output logic [15:0] ram_rdata_o
);
    logic [15:0] mem [64];
    logic [1:0] wait_q = 2'h0;
    logic [15:0] last_q = 16'h0000;
    initial ram_ack_o = 1'b0;
    // answer after delay_i idle cycles; the tb also writes mem directly
    always @(posedge clk_i) begin
        ram_ack_o <= 1'b0;
        if (ram_req_i && !ram_ack_o) begin
            if (wait_q < delay_i) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                wait_q <= 2'h0;
                ram_ack_o <= 1'b1;
                last_q <= mem[ram_addr_i[5:0]];
                if (ram_we_i) mem[ram_addr_i[5:0]] <= ram_wdata_i;
            end
        end
    end
    // released bus shows the inverse so stale data never looks valid
    assign ram_rdata_o = ram_ack_o ? last_q : ~last_q;
endmodule

// file: rtpp_buffer_select_props.sv
// port checks of the selector: bus answer, ram handshake, descriptor use
// assumes a single clock domain with synchronous reset
`timescale 1ns/1ns
module rtpp_buffer_select_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic start_valid_i,
    input rtpp_pkg::rtpp_start_type start_i,
    input wire logic start_ready_o,
    input wire logic buf_valid_o,
    input wire logic [12:0] buf_addr_o,
    input wire logic word_valid_i,
    input wire logic word_ready_o,
    input wire logic end_valid_i,
    input wire logic end_ready_o,
    input wire logic msg_done_o,
    input wire logic ram_req_o,
    input wire logic ram_we_o,
    input wire logic [12:0] ram_addr_o,
    input wire logic [15:0] ram_wdata_o,
    input wire logic ram_ack_i
);
    // ----
    // message tracking
    // ----
    logic [12:0] desc_q, desc_d;
    logic [7:0] k_q, k_d;
    logic first_q, first_d, busy_q, busy_d, xfer_q, xfer_d;
    // descriptor, first access and word index of the message in flight
    always_comb begin
        desc_d = desc_q;
        first_d = first_q && !ram_req_o;
        busy_d = busy_q && !msg_done_o;
        xfer_d = xfer_q && !(end_valid_i && end_ready_o);
        k_d = word_ready_o ? k_q + 8'h01 : k_q;
        if (start_valid_i && start_ready_o) begin
            desc_d = start_i.desc_addr;
            first_d = 1'b1;
            busy_d = 1'b1;
        end
        if (buf_valid_o) begin
            xfer_d = 1'b1;
            k_d = 8'h00;
        end
    end
    // registers only; the clear sweep runs with busy_q low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            desc_q <= 13'h0000;
            k_q <= 8'h00;
            first_q <= 1'b0;
            busy_q <= 1'b0;
            xfer_q <= 1'b0;
        end else begin
            desc_q <= desc_d;
            k_q <= k_d;
            first_q <= first_d;
            busy_q <= busy_d;
            xfer_q <= xfer_d;
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack width");
    AST_WB_UNMAPPED: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i[11:10] != 2'h0 |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read");
    AST_RAM_HOLD: assert property (ram_req_o && !ram_ack_i |=> ram_req_o && $stable(ram_addr_o)
        && $stable(ram_we_o) && $stable(ram_wdata_o))
        else $error("ram req moved");
    AST_FIRST_FETCH: assert property (first_q && ram_req_o |-> !ram_we_o && ram_addr_o == desc_q)
        else $error("no control fetch");
    AST_PTR_STATIC: assert property (busy_q && ram_req_o && ram_we_o |-> ram_addr_o != desc_q + 13'h0001 && ram_addr_o != desc_q + 13'h0002)
        else $error("pointer written");
    AST_WORD_PLACE: assert property (xfer_q && word_valid_i && ram_req_o |-> ram_addr_o == buf_addr_o + 13'h0002 + {5'h00, k_q})
        else $error("word misplaced");
    AST_BUF_PULSE: assert property (buf_valid_o |=> !buf_valid_o)
        else $error("buf valid width");
    AST_START_FETCH: assert property (start_valid_i && start_ready_o |-> ##[3:300] buf_valid_o)
        else $error("no buffer chosen");
    AST_DONE_PULSE: assert property (msg_done_o |=> !msg_done_o && !buf_valid_o)
        else $error("done width");
endmodule
bind rtpp_buffer_select rtpp_buffer_select_props rtpp_buffer_select_props_inst (.*);

// file: rtpp_buffer_select_test.sv
// self-checking bench for the double-buffer selector with a shared ram model
// assumes the package, the ram model and the checker are compiled first
`timescale 1ns/1ns
module rtpp_buffer_select_test;
    import rtpp_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, sv, sr, bv, wv, wwe, wrdy, ev, er, done, req, rwe, rack;
    logic b;
    logic [1:0] dly;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] wdat, rdat, r;
    logic [12:0] ba, raddr, o;
    logic [15:0] wwd, wrd, rwd, rrd, c;
    rtpp_start_type st;
    rtpp_end_type ed;
    int err_total, n_checks, cyc_cnt;
    rtpp_buffer_select #(.RAM_WORDS(64)) rtpp_buffer_select_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .start_valid_i(sv), .start_i(st),
        .start_ready_o(sr), .buf_valid_o(bv), .buf_addr_o(ba), .word_valid_i(wv),
        .word_we_i(wwe), .word_wdata_i(wwd), .word_ready_o(wrdy), .word_rdata_o(wrd),
        .end_valid_i(ev), .end_i(ed), .end_ready_o(er), .msg_done_o(done), .ram_req_o(req),
        .ram_we_o(rwe), .ram_addr_o(raddr), .ram_wdata_o(rwd), .ram_ack_i(rack), .ram_rdata_i(rrd));
    rtpp_ram_model rtpp_ram_model_inst (.clk_i(clk_i), .delay_i(dly), .ram_req_i(req),
        .ram_we_i(rwe), .ram_addr_i(raddr), .ram_wdata_i(rwd), .ram_ack_o(rack), .ram_rdata_o(rrd));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    function automatic logic [15:0] rd(input logic [12:0] a);
        return rtpp_ram_model_inst.mem[a[5:0]];
    endfunction
    task automatic wr(input logic [12:0] a, input logic [15:0] d);
        rtpp_ram_model_inst.mem[a[5:0]] = d;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard: about seventeen times the expected run
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    // ----
    // drivers: every task starts and ends just after a rising edge
    // ----
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (!ack);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // one message of two words on the descriptor at 0x10
    task automatic msg(input logic bc, input logic w, input logic [4:0] fl);
        sv <= 1'b1;
        st <= '{13'h0010, bc};
        do @(posedge clk_i); while (!sr);
        sv <= 1'b0;
        do @(posedge clk_i); while (!bv);
        for (int k = 0; k < 2; k++) begin
            wv <= 1'b1;
            wwe <= w;
            wwd <= 16'h00A0 + 16'(k);
            do @(posedge clk_i); while (!wrdy);
            if (!w) check(32'(wrd), 32'(rd(ba + 13'(k) + 13'h2)));
            wv <= 1'b0;
            @(posedge clk_i);
        end
        ev <= 1'b1;
        ed <= {16'h1234, 16'h5678, fl};
        do @(posedge clk_i); while (!er);
        ev <= 1'b0;
        do @(posedge clk_i); while (!done);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_basic;
        check(32'({rd(13'h20), rd(13'h22)}), 32'h0);
        wr(13'h10, 16'h0100);
        wr(13'h11, 16'h0020);
        wr(13'h12, 16'h0028);
        wr(13'h13, 16'h0030);
        bus(1'b0, 12'hC00, 32'h0, r);
        check(r, 32'h0);
        msg(1'b0, 1'b1, 5'h11);
        check(32'(ba), 32'h20);
        c = rd(13'h10);
        check(32'(c[11:8]), 32'hD);
        check(32'({rd(13'h11), rd(13'h12)}), 32'h00200028);
        check(32'({rd(13'h22), rd(13'h20)}), 32'h00A01234);
        msg(1'b0, 1'b1, 5'h11);
        check(32'(ba), 32'h28);
        $display("t_basic done");
    endtask
    // flags {complete, error, illegal, busy, legal count} with suppress off, then on
    task automatic t_toggle;
        logic [4:0] fl [6];
        fl = '{5'h01, 5'h19, 5'h15, 5'h13, 5'h10, 5'h11};
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, 12'h134, 32'(s * 2), r);
            for (int i = 0; i < 6; i++) begin
                c = rd(13'h10);
                b = c[CW_BUF_SEL_BIT];
                msg(1'b0, 1'b1, fl[i]);
                check(32'(ba), b ? 32'h28 : 32'h20);
                c = rd(13'h10);
                check(32'(c[CW_BUF_SEL_BIT]), 32'(b ^ (s == 0 ? i > 1 : i == 5)));
            end
        end
        $display("t_toggle done");
    endtask
    task automatic t_suspend;
        dly <= 2'h2;
        c = rd(13'h10);
        b = c[CW_BUF_SEL_BIT];
        wr(13'h10, c | 16'h0200);
        o = b ? 13'h20 : 13'h28;
        wr(o + 13'h2, 16'hBEEF);
        repeat (2) begin
            msg(1'b0, 1'b0, 5'h11);
            check(32'(ba), b ? 32'h28 : 32'h20);
            c = rd(13'h10);
            check(32'({c[CW_ACK_BIT], c[CW_BUF_SEL_BIT]}), 32'({1'b0, b}));
        end
        check(32'(rd(o + 13'h2)), 32'hBEEF);
        wr(13'h10, c & 16'hFDFF);
        msg(1'b0, 1'b1, 5'h11);
        c = rd(13'h10);
        check(32'({c[CW_ACK_BIT], c[CW_BUF_SEL_BIT]}), 32'({1'b1, !b}));
        dly <= 2'h0;
        $display("t_suspend done");
    endtask
    task automatic t_bcast;
        bus(1'b1, 12'h140, 32'h1, r);
        c = rd(13'h10);
        b = c[CW_BUF_SEL_BIT];
        repeat (2) begin
            msg(1'b1, 1'b1, 5'h11);
            check(32'(ba), 32'h30);
        end
        c = rd(13'h10);
        check(32'(c[CW_BUF_SEL_BIT]), 32'(b));
        bus(1'b0, 12'h144, 32'h0, r);
        check(32'(r[ST_LAST_BCAST_BIT]), 32'h1);
        $display("t_bcast done");
    endtask
    initial begin
        {rst_i, cyc, stb, we, sv, wv, wwe, ev} = 8'h80;
        {adr, wdat, wwd, dly} = '0;
        st = '0;
        ed = '0;
        err_total = 0;
        n_checks = 0;
        cyc_cnt = 0;
        sel = 4'h3;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        do @(posedge clk_i); while (!sr);
        bus(1'b0, 12'h134, 32'h0, r);
        check(r, 32'(EXT_CFG_RST));
        t_basic;
        t_toggle;
        t_suspend;
        t_bcast;
        give_verdict;
    end
endmodule
